//--- cct_timer.sv
// The address map and the address-and-strobe port were chosen for this implementation.
module cct_timer
	import cct_pkg::*;
#(
	parameter int CNT_W  = 16,
	parameter int NUM_CH = 4
) (
	input  wire logic               clk_sys,
	input  wire logic               rst,
	input  wire cct_pkg::cct_bus_req_s bus_req,
	output logic [31:0]             bus_rdata,
	input  wire cct_pkg::cct_pins_s pins,
	output logic                    overflow_irq,
	output logic [NUM_CH-1:0]       channel_irq,
	output logic                    timer_output_0,
	output logic                    timer_output_1
);

	// ************************************************************
	// elaboration checks
	// ************************************************************
	if (CNT_W != 16) begin : g_bad_width
		$error("cct_timer supports a 16-bit counter only");
	end
	if (NUM_CH != 4) begin : g_bad_ch
		$error("cct_timer needs exactly four channels");
	end
	// edge configuration holds two bits per trigger plus the clear pair
	if (2 * NUM_CH + 2 != $bits(RST_EDGE)) begin : g_bad_edge
		$error("cct_timer edge configuration does not fit NUM_CH");
	end

	// ************************************************************
	// pin indices and state record
	// ************************************************************
	localparam int NPIN = NUM_CH + 2;
	localparam int PIN_CNT = 0;
	localparam int PIN_CLR = 1;

	typedef struct packed {
		logic [NPIN-1:0]             sync1;
		logic [NPIN-1:0]             sync2;
		logic [NPIN-1:0]             prev;
		logic [5:0]                  pre;
		logic                        ce;
		logic                        src;
		logic [2:0]                  prs;
		logic [NUM_CH-1:0]           cmp_mode;
		logic [1:0]                  tes;
		logic                        ost;
		logic                        eclr;
		logic [9:0]                  edge_cfg;
		logic [3:0]                  outc;
		logic                        ovf_flag;
		cct_run_e                    run;
		logic [CNT_W-1:0]            cnt;
		logic                        counted;
		logic [NUM_CH-1:0][CNT_W-1:0] cc;
		logic                        ff0;
		logic                        ff1;
		logic                        ovf_pulse;
		logic [NUM_CH-1:0]           irq;
		logic                        pin0;
		logic                        pin1;
		logic [31:0]                 rdata;
	} cct_state_s;

	cct_state_s s;
	cct_state_s next_s;

	// ************************************************************
	// helpers
	// ************************************************************
	// the reserved code 10 matches nothing, so a stray setting just stops
	// counting instead of counting on a guessed edge
	function automatic logic edge_hit(input logic [1:0] sel,
		input logic rise, input logic fall);
		logic hit;
		hit = 1'b0;
		case (sel)
			EDGE_RISE: hit = rise;
			EDGE_FALL: hit = fall;
			EDGE_BOTH: hit = rise | fall;
			default:   hit = 1'b0;
		endcase
		return hit;
	endfunction : edge_hit

	function automatic logic [5:0] pre_mask(input logic [2:0] sel);
		logic [5:0] m;
		m = 6'h3F;
		case (sel)
			3'b000:          m = 6'h01;
			3'b001:          m = 6'h03;
			3'b010:          m = 6'h07;
			3'b011, 3'b100:  m = 6'h0F;
			3'b101, 3'b110:  m = 6'h1F;
			default:         m = 6'h3F;
		endcase
		return m;
	endfunction : pre_mask

	// ************************************************************
	// combinational nets
	// ************************************************************
	logic [NPIN-1:0]   rise;
	logic [NPIN-1:0]   fall;
	logic              tick;
	logic              clr_edge;
	logic              ce_set;
	logic [NUM_CH-1:0] trig_hit;
	logic [NUM_CH-1:0] match;
	logic [31:0]       rd_val;

	// ************************************************************
	// next-state logic
	// ************************************************************
	always_comb begin
		next_s = s;

		// ********************************************************
		// synchronisers and edge detect
		// ********************************************************
		// a pin change reaches the logic on the third edge; a level held
		// under one cycle can be lost, which bounds the count rate
		// first stage only feeds the second
		next_s.sync1 = {pins.trig, pins.clear_in, pins.count_in};
		next_s.sync2 = s.sync1;
		next_s.prev  = s.sync2;
		rise = s.sync2 & ~s.prev;
		fall = ~s.sync2 & s.prev;
		// the prescaler is never reloaded on start, so the first tick may
		// come early; that jitter is accepted to save a reload path
		next_s.pre = s.pre + 6'h01;

		// ********************************************************
		// count tick
		// ********************************************************
		// count source and edge choice
		if (s.src) begin
			tick = edge_hit(s.tes, rise[PIN_CNT], fall[PIN_CNT]);
		end else begin
			tick = (s.pre & pre_mask(s.prs)) == pre_mask(s.prs);
		end
		clr_edge = edge_hit(s.edge_cfg[EDGE_CLR_LO +: 2],
			rise[PIN_CLR], fall[PIN_CLR]);
		ce_set = bus_req.wr && bus_req.addr == OFS_CTRL
			&& bus_req.wdata[CTRL_CE];

		// ********************************************************
		// register writes
		// ********************************************************
		if (bus_req.wr) begin
			if (bus_req.addr == OFS_CTRL) begin
				next_s.ce  = bus_req.wdata[CTRL_CE];
				next_s.src = bus_req.wdata[CTRL_SRC];
				next_s.prs = bus_req.wdata[CTRL_PRS_LO +: 3];
			end else if (bus_req.addr == OFS_MODE) begin
				next_s.cmp_mode = bus_req.wdata[MODE_CMP_LO +: NUM_CH];
				next_s.tes      = bus_req.wdata[MODE_TES_LO +: 2];
				next_s.ost      = bus_req.wdata[MODE_OST];
				next_s.eclr     = bus_req.wdata[MODE_ECLR];
			end else if (bus_req.addr == OFS_EDGE) begin
				next_s.edge_cfg = bus_req.wdata[9:0];
			end else if (bus_req.addr == OFS_OUTC) begin
				next_s.outc = bus_req.wdata[3:0];
			end else if (bus_req.addr == OFS_OVFS) begin
				next_s.ovf_flag = bus_req.wdata[0];
			end else begin
				for (int k = 0; k < NUM_CH; k++) begin
					if (bus_req.addr == OFS_CC0 + 8'(k) * CC_STRIDE) begin
						next_s.cc[k] = bus_req.wdata[CNT_W-1:0];
					end
				end
			end
		end

		// ********************************************************
		// run control and counter
		// ********************************************************
		next_s.counted   = 1'b0;
		next_s.ovf_pulse = 1'b0;
		case (s.run)
			CCT_IDLE: begin
				if (ce_set) begin
					next_s.run = s.eclr ? CCT_ARM : CCT_RUN;
				end
			end
			CCT_ARM: begin
				if (clr_edge) begin
					next_s.cnt = '0;
					next_s.run = CCT_RUN;
				end
			end
			CCT_RUN: begin
				// a write of ce=1 here falls through unchanged
				if (s.eclr && clr_edge) begin
					next_s.cnt = '0;
				end else if (tick) begin
					next_s.cnt     = s.cnt + 16'h0001;
					next_s.counted = 1'b1;
					if (s.cnt == 16'hFFFF) begin
						next_s.ovf_pulse = 1'b1;
						if (s.ost) begin
							next_s.run = s.eclr ? CCT_HALT_CLR : CCT_HALT;
							next_s.ce  = s.eclr;
						end
					end
				end
			end
			CCT_HALT: begin
				if (ce_set) begin
					next_s.run = CCT_RUN;
				end
			end
			CCT_HALT_CLR: begin
				// ce=1 writes are ignored, only the clear pin restarts
				if (clr_edge) begin
					next_s.cnt = '0;
					next_s.run = CCT_RUN;
				end
			end
			default: next_s.run = CCT_IDLE;
		endcase
		// clearing ce stops the timer in any state
		if (bus_req.wr && bus_req.addr == OFS_CTRL
			&& !bus_req.wdata[CTRL_CE]) begin
			next_s.run = CCT_IDLE;
		end
		// hardware set wins over a software clear in the same cycle
		if (next_s.ovf_pulse) begin
			next_s.ovf_flag = 1'b1;
		end

		// ********************************************************
		// capture and compare channels
		// ********************************************************
		for (int k = 0; k < NUM_CH; k++) begin
			trig_hit[k] = edge_hit(s.edge_cfg[2*k +: 2],
				rise[k+2], fall[k+2]);
			// match only one cycle after a count-up, never after a clear
			match[k] = s.cmp_mode[k] && s.counted
				&& s.cnt == s.cc[k];
			// a trigger on a compare channel interrupts but keeps the value
			if (trig_hit[k] && !s.cmp_mode[k]) begin
				next_s.cc[k] = s.cnt;
			end
			next_s.irq[k] = trig_hit[k] | match[k];
		end

		// ********************************************************
		// output flip-flops
		// ********************************************************
		if (bus_req.wr && bus_req.addr == OFS_OUTC) begin
			if (bus_req.wdata[OUTC_LD0]) begin
				next_s.ff0 = bus_req.wdata[OUTC_LV0];
			end
			if (bus_req.wdata[OUTC_LD1]) begin
				next_s.ff1 = bus_req.wdata[OUTC_LV1];
			end
		end
		// a match beats a software load in the same cycle
		if (match[1]) begin
			next_s.ff0 = 1'b0;
		end else if (match[0]) begin
			next_s.ff0 = 1'b1;
		end
		if (match[3]) begin
			next_s.ff1 = 1'b0;
		end else if (match[2]) begin
			next_s.ff1 = 1'b1;
		end
		// disabled output sits at its inactive level
		next_s.pin0 = next_s.outc[OUTC_ALV0]
			? (next_s.outc[OUTC_EN0] & next_s.ff0)
			: ~(next_s.outc[OUTC_EN0] & next_s.ff0);
		next_s.pin1 = next_s.outc[OUTC_ALV1]
			? (next_s.outc[OUTC_EN1] & next_s.ff1)
			: ~(next_s.outc[OUTC_EN1] & next_s.ff1);

		// ********************************************************
		// read path
		// ********************************************************
		rd_val = 32'h0000_0000;
		if (bus_req.addr == OFS_CTRL) begin
			rd_val[CTRL_CE]           = s.ce;
			rd_val[CTRL_SRC]          = s.src;
			rd_val[CTRL_PRS_LO +: 3]  = s.prs;
			rd_val[CTRL_RUN]          = s.run == CCT_RUN;
		end else if (bus_req.addr == OFS_MODE) begin
			rd_val[MODE_CMP_LO +: NUM_CH] = s.cmp_mode;
			rd_val[MODE_TES_LO +: 2]      = s.tes;
			rd_val[MODE_OST]              = s.ost;
			rd_val[MODE_ECLR]             = s.eclr;
		end else if (bus_req.addr == OFS_EDGE) begin
			rd_val[9:0] = s.edge_cfg;
		end else if (bus_req.addr == OFS_OUTC) begin
			rd_val[3:0]      = s.outc;
			rd_val[OUTC_LV0] = s.ff0;
			rd_val[OUTC_LV1] = s.ff1;
		end else if (bus_req.addr == OFS_OVFS) begin
			rd_val[0] = s.ovf_flag;
		end else if (bus_req.addr == OFS_CNT) begin
			rd_val[CNT_W-1:0] = s.cnt;
		end else begin
			for (int k = 0; k < NUM_CH; k++) begin
				if (bus_req.addr == OFS_CC0 + 8'(k) * CC_STRIDE) begin
					rd_val[CNT_W-1:0] = s.cc[k];
				end
			end
		end
		// zero outside the answer cycle, so several slaves can be or-ed
		next_s.rdata = bus_req.rd ? rd_val : 32'h0000_0000;
	end

	// ************************************************************
	// state register
	// ************************************************************
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s          <= '0;
			// control and mode fields start from the package reset words
			s.ce       <= RST_CTRL[CTRL_CE];
			s.src      <= RST_CTRL[CTRL_SRC];
			s.prs      <= RST_CTRL[CTRL_PRS_LO +: 3];
			s.cmp_mode <= RST_MODE[NUM_CH-1:0];
			s.tes      <= RST_MODE[MODE_TES_LO +: 2];
			s.ost      <= RST_MODE[MODE_OST];
			s.eclr     <= RST_MODE[MODE_ECLR];
			s.edge_cfg <= RST_EDGE;
			s.outc     <= RST_OUTC;
			s.run      <= CCT_IDLE;
			// alv=0 means active low, so idle level is high
			s.pin0     <= 1'b1;
			s.pin1     <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ************************************************************
	// output ports
	// ************************************************************
	assign bus_rdata      = s.rdata;
	assign overflow_irq   = s.ovf_pulse;
	assign channel_irq    = s.irq;
	assign timer_output_0 = s.pin0;
	assign timer_output_1 = s.pin1;

endmodule : cct_timer

//--- cct_pkg.sv
package cct_pkg;

	// ************************************************************
	// register offsets (byte addresses)
	// ************************************************************
	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_MODE  = 8'h04;
	localparam logic [7:0] OFS_EDGE  = 8'h08;
	localparam logic [7:0] OFS_OUTC  = 8'h0C;
	localparam logic [7:0] OFS_OVFS  = 8'h10;
	localparam logic [7:0] OFS_CNT   = 8'h14;
	localparam logic [7:0] OFS_CC0   = 8'h20;
	localparam logic [7:0] CC_STRIDE = 8'h04;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int CTRL_CE      = 0;
	localparam int CTRL_SRC     = 1;
	localparam int CTRL_PRS_LO  = 2;
	localparam int CTRL_RUN     = 7;
	localparam int MODE_CMP_LO  = 0;
	localparam int MODE_TES_LO  = 4;
	localparam int MODE_OST     = 6;
	localparam int MODE_ECLR    = 7;
	localparam int EDGE_CLR_LO  = 8;
	localparam int OUTC_EN0     = 0;
	localparam int OUTC_ALV0    = 1;
	localparam int OUTC_EN1     = 2;
	localparam int OUTC_ALV1    = 3;
	localparam int OUTC_LD0     = 4;
	localparam int OUTC_LV0     = 5;
	localparam int OUTC_LD1     = 6;
	localparam int OUTC_LV1     = 7;

	// ************************************************************
	// reset values and edge codes
	// ************************************************************
	localparam logic [7:0]  RST_CTRL = 8'h00;
	localparam logic [7:0]  RST_MODE = 8'h00;
	localparam logic [9:0]  RST_EDGE = 10'h000;
	localparam logic [3:0]  RST_OUTC = 4'h0;
	localparam logic [1:0]  EDGE_RISE = 2'h0;
	localparam logic [1:0]  EDGE_FALL = 2'h1;
	localparam logic [1:0]  EDGE_BOTH = 2'h3;

	typedef enum logic [2:0] {
		CCT_IDLE     = 3'b000,
		CCT_ARM      = 3'b001,
		CCT_RUN      = 3'b010,
		CCT_HALT     = 3'b011,
		CCT_HALT_CLR = 3'b100
	} cct_run_e;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} cct_bus_req_s;

	typedef struct packed {
		logic       count_in;
		logic       clear_in;
		logic [3:0] trig;
	} cct_pins_s;

endpackage : cct_pkg

//--- cct_checker.sv
// ********
// port checker
// ********
module cct_checker #(
	parameter int CNT_W  = 16,
	parameter int NUM_CH = 4
) (
	input wire logic                  clk_sys,
	input wire logic                  rst,
	input wire cct_pkg::cct_bus_req_s bus_req,
	input wire logic [31:0]           bus_rdata,
	input wire cct_pkg::cct_pins_s    pins,
	input wire logic                  overflow_irq,
	input wire logic [NUM_CH-1:0]     channel_irq,
	input wire logic                  timer_output_0,
	input wire logic                  timer_output_1
);
	timeunit 1ns;
	timeprecision 1ps;
	import cct_pkg::*;
	logic [9:0] ecfg;
	logic [1:0] eo;
	logic       oc;
	logic [31:0] wd;
	assign oc = bus_req.wr && bus_req.addr == OFS_OUTC;
	assign wd = bus_req.wdata;
	// mirrors of written fields, since the checker cannot read registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ecfg <= RST_EDGE;
			eo   <= 2'h3;
		end else begin
			if (bus_req.wr && bus_req.addr == OFS_EDGE) begin
				ecfg <= wd[9:0];
			end
			if (oc) begin
				eo <= {wd[3] ~^ wd[7], wd[1] ~^ wd[5]};
			end
		end
	end
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	rdata_idle_a: assert property (
		!$past(bus_req.rd) |-> bus_rdata == '0)
		else $error("read data not zero while idle");
	unmapped_read_a: assert property (
		bus_req.rd && bus_req.addr == 8'hF0 |=> bus_rdata == '0)
		else $error("unmapped read not zero");
	ovf_pulse_a: assert property (
		overflow_irq |=> !overflow_irq)
		else $error("overflow irq longer than one cycle");
	irq_pulse_a: assert property (
		|channel_irq |=> (channel_irq & $past(channel_irq)) == '0)
		else $error("channel irq longer than one cycle");
	trig_rise_a: assert property (
		$rose(pins.trig[0]) && ecfg[1:0] == EDGE_RISE
		|-> ##[1:6] channel_irq[0])
		else $error("rising trigger gave no irq");
	trig_fall_a: assert property (
		$fell(pins.trig[1]) && ecfg[3:2] == EDGE_FALL
		|-> ##[1:6] channel_irq[1])
		else $error("falling trigger gave no irq");
	out0_load_a: assert property (
		oc && wd[0] && wd[4] |-> ##[1:2] timer_output_0 == eo[0])
		else $error("output 0 level after load wrong");
	out1_load_a: assert property (
		oc && wd[2] && wd[6] |-> ##[1:2] timer_output_1 == eo[1])
		else $error("output 1 level after load wrong");
	reset_out_a: assert property (
		$fell(rst) |-> timer_output_0 && timer_output_1 && !overflow_irq)
		else $error("outputs not idle after reset");
	cover property (overflow_irq);
	cover property (channel_irq[0] ##1 timer_output_0);
	cover property ($rose(pins.clear_in));
endmodule : cct_checker

bind cct_timer cct_checker #(.CNT_W(CNT_W), .NUM_CH(NUM_CH)) u_chk (
	.clk_sys(clk_sys), .rst(rst), .bus_req(bus_req),
	.bus_rdata(bus_rdata), .pins(pins), .overflow_irq(overflow_irq),
	.channel_irq(channel_irq), .timer_output_0(timer_output_0),
	.timer_output_1(timer_output_1));

//--- cct_pin_model.sv
// ********
// external pins
// ********
module cct_pin_model (
	input  wire logic         clk_sys,
	input  wire logic         count_run,
	output cct_pkg::cct_pins_s pins
);
	timeunit 1ns;
	timeprecision 1ps;
	import cct_pkg::*;
	initial pins = '0;
	// one toggle a cycle: the fastest the count input accepts
	always @(posedge clk_sys) begin
		if (count_run) begin
			pins.count_in <= ~pins.count_in;
		end
	end
	// levels held three cycles so the synchroniser always sees them
	task pulse(input logic [4:0] m);
		@(posedge clk_sys);
		{pins.clear_in, pins.trig} <= m;
		repeat (3) @(posedge clk_sys);
		{pins.clear_in, pins.trig} <= '0;
		repeat (3) @(posedge clk_sys);
	endtask : pulse
endmodule : cct_pin_model

//--- cct_timer_tb.sv
module cct_timer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import cct_pkg::*;
	logic         clk_sys = 1'b0;
	logic         rst = 1'b1;
	logic         run = 1'b0;
	cct_bus_req_s req = '0;
	cct_pins_s    pins;
	logic [31:0]  rdata, a, v;
	logic         ovf, t0, t1;
	logic [3:0]   irq;
	logic [4:0]   ev;
	int           error_cnt = 0;
	int           samples_checked = 0;
	int           dv[8] = '{2, 4, 8, 16, 16, 32, 32, 64};
	int           n;
	assign ev = {ovf, irq};
	always #4 clk_sys = ~clk_sys;
	cct_timer DUT (.clk_sys(clk_sys), .rst(rst), .bus_req(req),
		.bus_rdata(rdata), .pins(pins), .overflow_irq(ovf),
		.channel_irq(irq), .timer_output_0(t0), .timer_output_1(t1));
	cct_pin_model pm (.clk_sys(clk_sys), .count_run(run), .pins(pins));
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", s, e, g);
		end
	endtask : chk
	task bwr(input logic [7:0] ad, input logic [31:0] d);
		@(posedge clk_sys);
		req <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		req.wr <= 1'b0;
	endtask : bwr
	task brd(input logic [7:0] ad, output logic [31:0] d);
		@(posedge clk_sys);
		req <= '{addr: ad, wdata: '0, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		req.rd <= 1'b0;
		@(negedge clk_sys);
		d = rdata;
	endtask : brd
	task rchk(input string s, input logic [7:0] ad, input logic [31:0] e);
		brd(ad, v);
		chk(s, e, v);
	endtask : rchk
	task waitf(input int k, input int lim, input string s);
		int i;
		for (i = 0; i < lim; i++) begin
			@(negedge clk_sys);
			if (ev[k]) break;
		end
		chk(s, 32'h1, 32'(i < lim));
	endtask : waitf
	task counts(input int c);
		@(posedge clk_sys);
		run <= 1'b1;
		repeat (c) @(posedge clk_sys);
		run <= 1'b0;
		repeat (6) @(posedge clk_sys);
	endtask : counts
	task test_done;
		$display("checked %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : test_done
	initial begin
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		rchk("ctrl", OFS_CTRL, 32'h0);
		rchk("unmapped", 8'hF0, 32'h0);
		chk("outs", 32'h3, {30'h0, t1, t0});
		for (int p = 0; p < 8; p++) begin
			bwr(OFS_CTRL, 32'h0);
			bwr(OFS_CTRL, 32'((p << 2) | 1));
			brd(OFS_CNT, a);
			bwr(OFS_CTRL, 32'((p << 2) | 1));
			repeat (506) @(posedge clk_sys);
			brd(OFS_CNT, v);
			n = 16'(v - a);
			chk("rate", 32'h1, 32'(n * dv[p] >= 512 - dv[p] && n * dv[p] <= 512 + dv[p]));
		end
		bwr(OFS_CTRL, 32'h0);
		foreach (dv[e]) begin
			if (e == 0 || e == 1 || e == 3) begin
				bwr(OFS_MODE, 32'(e << 4));
				bwr(OFS_CTRL, 32'h3);
				brd(OFS_CNT, a);
				counts(200);
				brd(OFS_CNT, v);
				chk("ext count", (e == 3) ? 200 : 100, 16'(v - a));
				bwr(OFS_CTRL, 32'h0);
			end
		end
		bwr(OFS_MODE, 32'h0);
		bwr(OFS_EDGE, 32'h4);
		brd(OFS_CNT, a);
		fork
			pm.pulse(5'h01);
			waitf(0, 20, "cap irq 0");
		join
		fork
			pm.pulse(5'h02);
			waitf(1, 20, "cap irq 1");
		join
		rchk("cap 0", OFS_CC0, a);
		rchk("cap 1", OFS_CC0 + CC_STRIDE, a);
		bwr(OFS_MODE, 32'hF);
		bwr(OFS_CC0, a + 4);
		bwr(OFS_CC0 + 8'h04, a + 8);
		bwr(OFS_CC0 + 8'h08, a + 12);
		bwr(OFS_CC0 + 8'h0C, a + 12);
		bwr(OFS_OUTC, 32'h35);
		@(negedge clk_sys);
		chk("active low", 32'h2, {30'h0, t1, t0});
		bwr(OFS_OUTC, 32'hDF);
		@(negedge clk_sys);
		chk("load", 32'h2, {30'h0, t1, t0});
		bwr(OFS_CTRL, 32'h1);
		waitf(0, 40, "match 0");
		chk("set 0", 32'h1, {31'h0, t0});
		waitf(1, 40, "match 1");
		chk("reset 0", 32'h0, {31'h0, t0});
		waitf(2, 40, "match 2");
		chk("match 3", 32'h1, {31'h0, irq[3]});
		chk("reset wins", 32'h0, {31'h0, t1});
		bwr(OFS_CTRL, 32'h0);
		bwr(OFS_MODE, 32'h80);
		bwr(OFS_EDGE, 32'h0);
		bwr(OFS_CTRL, 32'h1);
		brd(OFS_CNT, a);
		repeat (20) @(posedge clk_sys);
		rchk("armed", OFS_CNT, a);
		pm.pulse(5'h10);
		repeat (100) @(posedge clk_sys);
		pm.pulse(5'h10);
		brd(OFS_CNT, v);
		chk("cleared", 32'h1, 32'(v < 16));
		bwr(OFS_CTRL, 32'h0);
		bwr(OFS_MODE, 32'h70);
		bwr(OFS_CTRL, 32'h3);
		run <= 1'b1;
		waitf(4, 70000, "overflow");
		run <= 1'b0;
		rchk("ovf flag", OFS_OVFS, 32'h1);
		rchk("ce cleared", OFS_CTRL, 32'h2);
		counts(20);
		rchk("halted", OFS_CNT, 32'h0);
		bwr(OFS_CTRL, 32'h3);
		counts(20);
		rchk("resumed", OFS_CNT, 32'h14);
		test_done();
	end
	initial begin
		repeat (90000) @(posedge clk_sys);
		error_cnt++;
		test_done();
	end
endmodule : cct_timer_tb
